// File: rtl/rcg_pkg.sv
// Shared constants for the reset and clock generation block and its host.
// Assumes a single 40 MHz system clock on both ends.
package rcg_pkg;
   // Clock rate and timing figures, each with its derived cycle count.
   localparam int SYS_CLK_MHZ = 40;
   localparam int RESET_DELAY_US = 100;
   localparam int RESET_DELAY_CYC = RESET_DELAY_US * SYS_CLK_MHZ;
   localparam int POR_HOLD_US = 100;
   localparam int POR_HOLD_CYC = POR_HOLD_US * SYS_CLK_MHZ;
   localparam int PLL_SETTLE_US = 500;
   localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * SYS_CLK_MHZ;

   // Device register offsets on the configuration port.
   localparam logic [7:0] DOT_CFG_ADDR = 8'h24;
   localparam logic [7:0] DEV_STAT_ADDR = 8'h28;
   localparam logic [7:0] ISA_DIV_ADDR = 8'h50;

   // Reset values and the writable mask of the dot clock register.
   localparam logic [31:0] DOT_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] DOT_CFG_WMASK = 32'hDFFF_FD07;
   localparam logic [7:0] ISA_DIV_RESET = 8'h7B;

   // Field positions of the dot clock register and the ISA divisor register.
   localparam int FB_RESET_BIT = 31;
   localparam int HALF_OFF_BIT = 30;
   localparam int PD_MSB = 28;
   localparam int PD_LSB = 24;
   localparam int FD_ODD_BIT = 23;
   localparam int N_MSB = 22;
   localparam int N_LSB = 12;
   localparam int PLL_ON_BIT = 11;
   localparam int TV_SEL_BIT = 10;
   localparam int BYPASS_BIT = 8;
   localparam int ID_MSB = 2;
   localparam int ID_LSB = 0;
   localparam int ISA_DIV_MSB = 2;

   // Special codes and offsets of the divisor fields.
   localparam logic [4:0] PD_UNITY_CODE = 5'h0F;
   localparam logic [3:0] ID_OFFSET = 4'h2;
   localparam logic [3:0] ISA_OFFSET = 4'h1;
   localparam logic [10:0] LFSR_N_ONE = 11'h3FF;
   localparam logic [10:0] LFSR_N_LAST = 11'h7FF;

   // Post divisor for each five-bit code; zero marks the reserved code.
   localparam logic [4:0] PD_TABLE [32] = '{
      5'h08, 5'h06, 5'h12, 5'h04, 5'h0C, 5'h10, 5'h18, 5'h02,
      5'h0A, 5'h14, 5'h0E, 5'h1A, 5'h16, 5'h1C, 5'h1E, 5'h01,
      5'h09, 5'h07, 5'h13, 5'h05, 5'h0D, 5'h11, 5'h19, 5'h03,
      5'h0B, 5'h15, 5'h0F, 5'h1B, 5'h17, 5'h1D, 5'h1F, 5'h00};

   // Host register offsets on its software port.
   localparam logic [7:0] HOST_ISA_ADDR = 8'h00;
   localparam logic [7:0] HOST_DOT_ADDR = 8'h04;
   localparam logic [7:0] HOST_CMD_ADDR = 8'h08;
   localparam logic [7:0] HOST_STAT_ADDR = 8'h0C;
   localparam logic [7:0] HOST_MIRROR_ADDR = 8'h10;
endpackage : rcg_pkg

// File: rtl/rcg_link_if.sv
// Link between the reset and clock generator and the host that drives it.
// Both ends run on the same system clock; no clocking block is used.
`timescale 1ns/10ps
interface rcg_link_if;
   logic power_on_reset_n;
   logic pci_bus_reset_n;
   logic cpu_reset;
   logic isa_bus_clock;
   logic pixel_dot_clock;
   logic [7:0] cfg_addr;
   logic [31:0] cfg_wdata;
   logic cfg_wr;
   logic cfg_rd;
   logic [31:0] cfg_rdata;

   modport device (
      input power_on_reset_n,
      input cfg_addr,
      input cfg_wdata,
      input cfg_wr,
      input cfg_rd,
      output pci_bus_reset_n,
      output cpu_reset,
      output isa_bus_clock,
      output pixel_dot_clock,
      output cfg_rdata
   );

   modport host (
      output power_on_reset_n,
      output cfg_addr,
      output cfg_wdata,
      output cfg_wr,
      output cfg_rd,
      input pci_bus_reset_n,
      input cpu_reset,
      input isa_bus_clock,
      input pixel_dot_clock,
      input cfg_rdata
   );
endinterface : rcg_link_if

// File: rtl/rcg_device.sv
// Reset and clock generator: bus and processor resets, ISA clock divider,
// dot clock PLL configuration and output select.
// Assumes the system clock is the PCI clock and that the PLL itself is an
// outside macro fed by the scaler outputs.
// Function
// [R1] Release both resets 100 us after power-on.
// [R2] Power-on held at least 100 us.
// [R3] ISA clock divides PCI clock by field.
// [R4] ISA code zero reserved, others select divisor.
// [R5] Software keeps ISA clock near 8.33 MHz.
// [R6] Dot clock configured through offset 24h.
// [R7] Software keeps dot clock within range.
// [R8] Dot clock from reference, feedback, post, input.
// [R9] Software keeps VCO between 140 and 300.
// [R10] Post and input divisor field positions.
// [R11] Feedback is twice N plus odd bit.
// [R12] Post code maps through fixed table.
// [R13] Input divisor equals code plus two.
// [R14] Software sequences reset, bypass, settle, release.
// [R15] Enable, TV select, bypass; unity forces enable.
// [R16] N field is LFSR pattern, translated.
// [R17] ISA divisor reloads only at boundary.
`timescale 1ns/10ps
module rcg_device (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   rcg_link_if.device link,
   input wire logic i_reference_osc_in,
   input wire logic i_tv_encoder_clock_in,
   input wire logic i_pll_vco_out,
   output logic [3:0] o_pll_input_scaler,
   output logic [11:0] o_pll_feedback_scaler,
   output logic [4:0] o_pll_post_scaler,
   output logic o_pll_enable,
   output logic o_pll_fb_reset,
   output logic o_pll_bypass,
   output logic o_pll_half_clock_off
);
   import rcg_pkg::*;

   logic [31:0] dot_cfg;
   logic [7:0] isa_cfg;
   logic por_prev;
   logic reset_hold;
   logic [12:0] rst_cnt;
   logic [3:0] isa_div;
   logic [3:0] isa_cnt;
   logic [10:0] lfsr_state;
   logic [10:0] lfsr_target;
   logic [10:0] lfsr_count;
   logic [10:0] n_binary;
   logic n_valid;
   logic searching;

   // Register decode on the configuration port.
   wire dot_sel = link.cfg_addr == DOT_CFG_ADDR;
   wire isa_sel = link.cfg_addr == ISA_DIV_ADDR;
   wire stat_sel = link.cfg_addr == DEV_STAT_ADDR;
   wire dot_wr = link.cfg_wr && dot_sel;
   wire isa_wr = link.cfg_wr && isa_sel;
   wire [31:0] stat_word = {14'h0000, reset_hold, n_valid, 5'h00, n_binary};
   wire [31:0] next_rdata = !link.cfg_rd ? 32'h0000_0000 :
                            dot_sel ? dot_cfg :
                            isa_sel ? {24'h00_0000, isa_cfg} :
                            stat_sel ? stat_word : 32'h0000_0000;

   // [R6] Dot clock register store.
   // Reserved bits are masked on write so they always read as zero.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         dot_cfg <= DOT_CFG_RESET;
         isa_cfg <= ISA_DIV_RESET;
         link.cfg_rdata <= 32'h0000_0000;
      end else if (i_clk_en) begin
         if (dot_wr) begin
            dot_cfg <= link.cfg_wdata & DOT_CFG_WMASK;
         end
         // [R3] ISA divisor field store.
         if (isa_wr) begin
            isa_cfg <= link.cfg_wdata[7:0];
         end
         link.cfg_rdata <= next_rdata;
      end
   end

   // [R1] Reset delay timing.
   // The count starts at each power-on assertion; release also waits for
   // the input to go inactive, so a short pulse cannot cut the delay.
   wire por_fell = por_prev && !link.power_on_reset_n;
   wire delay_done = rst_cnt == 13'(RESET_DELAY_CYC);
   wire next_hold = por_fell ? 1'b1 :
                    (delay_done && link.power_on_reset_n) ? 1'b0 : reset_hold;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         por_prev <= 1'b0;
         reset_hold <= 1'b1;
         rst_cnt <= 13'h0000;
         link.pci_bus_reset_n <= 1'b0;
         link.cpu_reset <= 1'b1;
      end else if (i_clk_en) begin
         por_prev <= link.power_on_reset_n;
         reset_hold <= next_hold;
         if (por_fell) begin
            rst_cnt <= 13'h0000;
         end else if (!delay_done) begin
            rst_cnt <= rst_cnt + 13'h0001;
         end
         // [R1] Drive both resets.
         link.pci_bus_reset_n <= !next_hold;
         link.cpu_reset <= next_hold;
      end
   end

   // [R4] ISA divisor decode.
   // Code zero is reserved, so the divider keeps its old ratio for it.
   wire [2:0] isa_code = isa_cfg[ISA_DIV_MSB:0];
   wire isa_code_ok = isa_code != 3'h0;
   wire [3:0] isa_code_div = {1'b0, isa_code} + ISA_OFFSET;
   wire isa_wrap = isa_cnt == (isa_div - 4'h1);
   // [R17] Reload at boundary.
   wire [3:0] next_isa_div = (isa_wrap && isa_code_ok) ? isa_code_div
                                                        : isa_div;
   wire [3:0] next_isa_cnt = isa_wrap ? 4'h0 : isa_cnt + 4'h1;

   // [R3] ISA clock divider.
   // High for the lower half of each period; odd ratios are short high.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         isa_div <= {1'b0, ISA_DIV_RESET[ISA_DIV_MSB:0]} + ISA_OFFSET;
         isa_cnt <= 4'h0;
         link.isa_bus_clock <= 1'b0;
      end else if (i_clk_en) begin
         isa_div <= next_isa_div;
         isa_cnt <= next_isa_cnt;
         link.isa_bus_clock <= next_isa_cnt < {1'b0, next_isa_div[3:1]};
      end
   end

   // [R16] LFSR pattern search.
   // The pattern is walked from the N of one upward; a pattern never met
   // before the last step leaves the feedback count invalid at zero. The
   // walk takes at most 2047 cycles, well inside the PLL settle time.
   wire [10:0] next_lfsr = {~(lfsr_state[9] ^ lfsr_state[0]),
                            lfsr_state[10:1]};
   wire lfsr_hit = lfsr_state == lfsr_target;
   // A rewrite with the same N keeps the result, so the later writes of a
   // change sequence do not void the count just before status is read.
   wire n_changed = link.cfg_wdata[N_MSB:N_LSB] != lfsr_target;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         lfsr_state <= LFSR_N_ONE;
         lfsr_target <= DOT_CFG_RESET[N_MSB:N_LSB];
         lfsr_count <= 11'h001;
         n_binary <= 11'h000;
         n_valid <= 1'b0;
         searching <= 1'b1;
      end else if (i_clk_en) begin
         if (dot_wr && n_changed) begin
            lfsr_state <= LFSR_N_ONE;
            lfsr_target <= link.cfg_wdata[N_MSB:N_LSB];
            lfsr_count <= 11'h001;
            n_valid <= 1'b0;
            searching <= 1'b1;
         end else if (searching) begin
            if (lfsr_hit) begin
               n_binary <= lfsr_count;
               n_valid <= 1'b1;
               searching <= 1'b0;
            end else if (lfsr_count == LFSR_N_LAST) begin
               n_binary <= 11'h000;
               searching <= 1'b0;
            end else begin
               lfsr_state <= next_lfsr;
               lfsr_count <= lfsr_count + 11'h001;
            end
         end
      end
   end

   // [R10] Post and input fields.
   wire [4:0] pd_code = dot_cfg[PD_MSB:PD_LSB];
   wire [2:0] id_code = dot_cfg[ID_MSB:ID_LSB];
   // [R12] Post divisor table.
   wire [4:0] pd_value = PD_TABLE[pd_code];
   // [R13] Input divisor offset.
   wire [3:0] id_value = {1'b0, id_code} + ID_OFFSET;
   // [R11] Feedback doubling plus odd.
   wire [11:0] fd_value = n_valid ? {n_binary, dot_cfg[FD_ODD_BIT]}
                                  : 12'h000;
   // [R15] Unity post forces enable.
   wire pll_on = dot_cfg[PLL_ON_BIT] || (pd_code == PD_UNITY_CODE);
   wire bypass = dot_cfg[BYPASS_BIT];
   // [R15] Output source select.
   // The clocks are sampled by the system clock, so this path only models
   // the source choice; a real part muxes them as clocks.
   wire next_dot = bypass ? i_reference_osc_in :
                   dot_cfg[TV_SEL_BIT] ? i_tv_encoder_clock_in :
                   pll_on ? i_pll_vco_out : 1'b0;

   // [R8] Scalers to the PLL.
   // The PLL forms reference times feedback over post times input.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_pll_input_scaler <= 4'h0;
         o_pll_feedback_scaler <= 12'h000;
         o_pll_post_scaler <= 5'h00;
         o_pll_enable <= 1'b0;
         o_pll_fb_reset <= 1'b0;
         o_pll_bypass <= 1'b0;
         o_pll_half_clock_off <= 1'b0;
         link.pixel_dot_clock <= 1'b0;
      end else if (i_clk_en) begin
         o_pll_input_scaler <= id_value;
         o_pll_feedback_scaler <= fd_value;
         o_pll_post_scaler <= pd_value;
         o_pll_enable <= pll_on;
         o_pll_fb_reset <= dot_cfg[FB_RESET_BIT];
         o_pll_bypass <= bypass;
         o_pll_half_clock_off <= dot_cfg[HALF_OFF_BIT];
         link.pixel_dot_clock <= next_dot;
      end
   end
endmodule : rcg_device

// File: rtl/rcg_host.sv
// Host end: drives power-on reset and sequences configuration writes to
// the reset and clock generator on behalf of software.
// Assumes software reaches it through a plain strobe port on the same clock.
`timescale 1ns/10ps
module rcg_host #(
   parameter int PLL_SETTLE_CYCLES = rcg_pkg::PLL_SETTLE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   rcg_link_if.host link,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata
);
   import rcg_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE, H_ISA, H_DIV, H_RSTBYP, H_WAIT, H_CLRRST, H_CLRBYP,
      H_RDSTAT, H_RDWAIT, H_LATCH
   } rcg_host_state_type;

   rcg_host_state_type state;
   logic [7:0] isa_stage;
   logic [31:0] dot_stage;
   logic [31:0] dot_work;
   logic [31:0] mirror;
   logic isa_pend;
   logic dot_pend;
   logic [12:0] por_cnt;
   logic [19:0] wait_cnt;

   // Software port decode.
   wire wr_isa = i_wr && i_addr == HOST_ISA_ADDR;
   wire wr_dot = i_wr && i_addr == HOST_DOT_ADDR;
   wire wr_cmd = i_wr && i_addr == HOST_CMD_ADDR && i_wdata[0];
   wire busy = state != H_IDLE;
   wire [31:0] stat_word = {28'h000_0000, dot_pend, isa_pend,
                            link.power_on_reset_n, busy};
   wire [31:0] next_rdata = !i_rd ? 32'h0000_0000 :
                            i_addr == HOST_ISA_ADDR ? {24'h00_0000, isa_stage} :
                            i_addr == HOST_DOT_ADDR ? dot_stage :
                            i_addr == HOST_STAT_ADDR ? stat_word :
                            i_addr == HOST_MIRROR_ADDR ? mirror :
                            32'h0000_0000;
   wire por_done = por_cnt == 13'(POR_HOLD_CYC);
   wire settle_done = wait_cnt == 20'(PLL_SETTLE_CYCLES - 1);
   // Sequence words clear or set the feedback reset and bypass bits.
   wire [31:0] rst_byp = (32'h1 << FB_RESET_BIT) | (32'h1 << BYPASS_BIT);
   wire [31:0] only_byp = 32'h1 << BYPASS_BIT;

   // [R2] Power-on hold time.
   // The device clock must run throughout, so the count uses it too.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         por_cnt <= 13'h0000;
         link.power_on_reset_n <= 1'b0;
      end else if (i_clk_en) begin
         if (!por_done) begin
            por_cnt <= por_cnt + 13'h0001;
         end
         link.power_on_reset_n <= por_done;
      end
   end

   // Staging registers; a new request wins over the clear by the sequencer.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         isa_stage <= ISA_DIV_RESET;
         dot_stage <= DOT_CFG_RESET;
         isa_pend <= 1'b0;
         dot_pend <= 1'b0;
         o_rdata <= 32'h0000_0000;
      end else if (i_clk_en) begin
         // [R5] Software picks the divisor.
         if (wr_isa) begin
            isa_stage <= i_wdata[7:0];
         end
         // [R7] Software picks the frequency.
         if (wr_dot) begin
            dot_stage <= i_wdata;
         end
         isa_pend <= wr_isa || (isa_pend && state != H_ISA);
         dot_pend <= wr_cmd || (dot_pend && state != H_DIV);
         o_rdata <= next_rdata;
      end
   end

   // [R14] Dot clock change sequence.
   // Divisors are written first, then reset and bypass, the settle wait,
   // reset release and bypass release; the device status is read at end.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= H_IDLE;
         dot_work <= 32'h0000_0000;
         mirror <= 32'h0000_0000;
         wait_cnt <= 20'h0_0000;
         link.cfg_addr <= 8'h00;
         link.cfg_wdata <= 32'h0000_0000;
         link.cfg_wr <= 1'b0;
         link.cfg_rd <= 1'b0;
      end else if (i_clk_en) begin
         link.cfg_wr <= 1'b0;
         link.cfg_rd <= 1'b0;
         case (state)
            H_IDLE: begin
               if (por_done && isa_pend) begin
                  state <= H_ISA;
               end else if (por_done && dot_pend) begin
                  state <= H_DIV;
               end
            end
            H_ISA: begin
               link.cfg_addr <= ISA_DIV_ADDR;
               link.cfg_wdata <= {24'h00_0000, isa_stage};
               link.cfg_wr <= 1'b1;
               state <= H_IDLE;
            end
            H_DIV: begin
               // [R9] Software owns the VCO range.
               dot_work <= dot_stage & ~rst_byp;
               link.cfg_addr <= DOT_CFG_ADDR;
               link.cfg_wdata <= dot_stage & ~rst_byp;
               link.cfg_wr <= 1'b1;
               state <= H_RSTBYP;
            end
            H_RSTBYP: begin
               link.cfg_wdata <= dot_work | rst_byp;
               link.cfg_wr <= 1'b1;
               wait_cnt <= 20'h0_0000;
               state <= H_WAIT;
            end
            H_WAIT: begin
               wait_cnt <= wait_cnt + 20'h0_0001;
               if (settle_done) begin
                  state <= H_CLRRST;
               end
            end
            H_CLRRST: begin
               link.cfg_wdata <= dot_work | only_byp;
               link.cfg_wr <= 1'b1;
               state <= H_CLRBYP;
            end
            H_CLRBYP: begin
               link.cfg_wdata <= dot_work;
               link.cfg_wr <= 1'b1;
               state <= H_RDSTAT;
            end
            H_RDSTAT: begin
               link.cfg_addr <= DEV_STAT_ADDR;
               link.cfg_rd <= 1'b1;
               state <= H_RDWAIT;
            end
            H_RDWAIT: begin
               state <= H_LATCH;
            end
            H_LATCH: begin
               mirror <= link.cfg_rdata;
               state <= H_IDLE;
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule : rcg_host

// File: tb/rcg_link_sva.sv
// Checker for the link between the generator and its host.
// Assumes it sits beside the interface, on the one system clock.
`timescale 1ns/10ps
module rcg_link_sva #(
   parameter int SETTLE = 3000
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic power_on_reset_n,
   input wire logic pci_bus_reset_n,
   input wire logic cpu_reset,
   input wire logic isa_bus_clock,
   input wire logic pixel_dot_clock,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [31:0] cfg_rdata
);
   import rcg_pkg::*;
   int por_cnt;
   int settle_cnt;
   int run_cnt;
   logic por_q;
   logic isa_q;
   logic fb_set;
   logic byp_set;
   wire dot_wr = cfg_wr && cfg_addr == DOT_CFG_ADDR;
   wire por_fell = por_q && !power_on_reset_n;

   // The power-on and settle counts saturate so that a long run never wraps them into a pass.
   always_ff @(posedge i_sys_clk) begin
      por_q <= i_reset ? 1'h0 : power_on_reset_n;
      isa_q <= isa_bus_clock;
      por_cnt <= (i_reset || por_fell) ? 0 : por_cnt + (por_cnt < 99999);
      settle_cnt <= (dot_wr && cfg_wdata[FB_RESET_BIT]) ? 0 :
         settle_cnt + (settle_cnt < 99999);
      run_cnt <= (i_reset || isa_q != isa_bus_clock) ? 1 : run_cnt + 1;
      if (i_reset) begin
         fb_set <= 1'h0;
         byp_set <= 1'h0;
      end else if (dot_wr) begin
         fb_set <= cfg_wdata[FB_RESET_BIT];
         byp_set <= cfg_wdata[BYPASS_BIT];
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   property p_rst_late;
      $rose(pci_bus_reset_n) |-> por_cnt >= RESET_DELAY_CYC - 1;
   endproperty
   a_rst_late: assert property (p_rst_late)
      else $error("bus reset released too early");
   property p_rst_due;
      power_on_reset_n && por_cnt == RESET_DELAY_CYC + 8 |-> pci_bus_reset_n;
   endproperty
   a_rst_due: assert property (p_rst_due)
      else $error("bus reset not released in time");
   property p_rst_pair;
      cpu_reset == !pci_bus_reset_n;
   endproperty
   a_rst_pair: assert property (p_rst_pair)
      else $error("processor and bus resets disagree");
   property p_por_hold;
      $rose(power_on_reset_n) |-> por_cnt >= POR_HOLD_CYC - 1;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("power-on pulse too short");
   property p_no_early;
      !power_on_reset_n |-> !cfg_wr && !cfg_rd;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("request while power-on held");
   property p_isa_run;
      run_cnt <= 4;
   endproperty
   a_isa_run: assert property (p_isa_run)
      else $error("isa clock level held too long");
   property p_fb_with_byp;
      dot_wr && cfg_wdata[FB_RESET_BIT] |-> cfg_wdata[BYPASS_BIT];
   endproperty
   a_fb_with_byp: assert property (p_fb_with_byp)
      else $error("feedback reset set without bypass");
   property p_settle;
      dot_wr && fb_set && !cfg_wdata[FB_RESET_BIT] |-> settle_cnt >= SETTLE - 1;
   endproperty
   a_settle: assert property (p_settle)
      else $error("feedback reset cleared before settling");
   property p_byp_last;
      dot_wr && byp_set && !cfg_wdata[BYPASS_BIT] |-> !fb_set;
   endproperty
   a_byp_last: assert property (p_byp_last)
      else $error("bypass cleared before feedback reset");
   property p_stat;
      $past(cfg_rd) && $past(cfg_addr) == DEV_STAT_ADDR |->
         cfg_rdata[31:17] == 15'h0 && cfg_rdata[16];
   endproperty
   a_stat: assert property (p_stat)
      else $error("status word wrong after settling");
endmodule : rcg_link_sva

// File: tb/reset_and_clock_generation_bench.sv
// Bench joining the generator to its host across the link.
// Assumes one 40 MHz clock; software reaches only the host port.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   n_fail++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module reset_and_clock_generation_bench;
   import rcg_pkg::*;
   localparam int SETTLE = 3000;
   logic i_sys_clk = 1'h0;
   logic i_reset = 1'h1;
   logic [7:0] sw_addr = 8'h00;
   logic [31:0] sw_wdata = 32'h0;
   logic sw_wr = 1'h0;
   logic sw_rd = 1'h0;
   logic [31:0] sw_rdata;
   logic [2:0] src = 3'h0;
   logic [2:0] src_d = 3'h0;
   logic [3:0] in_sc;
   logic [11:0] fb_sc;
   logic [4:0] post_sc;
   logic pll_en;
   logic fb_rst;
   logic byp;
   logic half_off;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   rcg_link_if link ();

   always #12.5 i_sys_clk = ~i_sys_clk;

   // Source stand-ins run at three rates so a wrong selection shows; the
   // delayed copy is what a one-flop sampled output must equal.
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      src <= {cyc[0], cyc[1], cyc[2]};
      src_d <= src;
      if (cyc == 60000) begin
         n_fail++;
         print_verdict();
      end
   end

   rcg_device rcg_device_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_clk_en(1'h1), .link(link), .i_reference_osc_in(src[0]),
      .i_tv_encoder_clock_in(src[1]), .i_pll_vco_out(src[2]),
      .o_pll_input_scaler(in_sc), .o_pll_feedback_scaler(fb_sc),
      .o_pll_post_scaler(post_sc), .o_pll_enable(pll_en),
      .o_pll_fb_reset(fb_rst), .o_pll_bypass(byp),
      .o_pll_half_clock_off(half_off));
   rcg_host #(.PLL_SETTLE_CYCLES(SETTLE)) rcg_host_inst (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(1'h1),
      .link(link), .i_addr(sw_addr), .i_wdata(sw_wdata), .i_wr(sw_wr),
      .i_rd(sw_rd), .o_rdata(sw_rdata));
   rcg_link_sva #(.SETTLE(SETTLE)) rcg_link_sva_inst (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .power_on_reset_n(link.power_on_reset_n),
      .pci_bus_reset_n(link.pci_bus_reset_n), .cpu_reset(link.cpu_reset),
      .isa_bus_clock(link.isa_bus_clock),
      .pixel_dot_clock(link.pixel_dot_clock), .cfg_addr(link.cfg_addr),
      .cfg_wdata(link.cfg_wdata), .cfg_wr(link.cfg_wr),
      .cfg_rd(link.cfg_rd), .cfg_rdata(link.cfg_rdata));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Each strobe waits an edge first, so back-to-back calls never assign
   // a strobe twice in one time step.
   task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'h1;
      @(posedge i_sys_clk);
      sw_wr <= 1'h0;
   endtask : sw_write

   task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      sw_addr <= a;
      sw_rd <= 1'h1;
      @(posedge i_sys_clk);
      sw_rd <= 1'h0;
      #1;
      d = sw_rdata;
   endtask : sw_read

   task automatic tick();
      @(posedge i_sys_clk);
      #1;
   endtask : tick

   task automatic wait_idle();
      logic [31:0] s;
      s = 32'hF;
      for (int k = 0; k < 4000 && s[3:0] !== 4'h2; k++) begin
         sw_read(HOST_STAT_ADDR, s);
      end
      `CHK("idle", 4'h2, s[3:0])
   endtask : wait_idle

   task automatic isa_measure(output int hi, output int per);
      hi = 0;
      for (int k = 0; k < 20 && link.isa_bus_clock !== 1'h0; k++) tick();
      for (int k = 0; k < 20 && link.isa_bus_clock !== 1'h1; k++) tick();
      for (int k = 0; k < 20 && link.isa_bus_clock === 1'h1; k++) begin
         tick();
         hi++;
      end
      per = hi;
      for (int k = 0; k < 20 && link.isa_bus_clock === 1'h0; k++) begin
         tick();
         per++;
      end
   endtask : isa_measure

   task automatic src_check(input logic [1:0] sel);
      logic [3:0] v;
      for (int k = 0; k < 8; k++) begin
         tick();
         v = {1'h0, src_d};
         `CHK("dot_clk", v[sel], link.pixel_dot_clock)
      end
   endtask : src_check

   task automatic test_reset();
      logic [31:0] s;
      int t0;
      int hi;
      int per;
      t0 = cyc;
      `CHK("pci_rst", 1'h0, link.pci_bus_reset_n)
      `CHK("cpu_rst", 1'h1, link.cpu_reset)
      `CHK("por", 1'h0, link.power_on_reset_n)
      sw_read(HOST_STAT_ADDR, s);
      `CHK("por_wait", 1'h0, s[1])
      for (int k = 0; k < 4100 && link.pci_bus_reset_n !== 1'h1; k++) tick();
      `CHK("rel_time", 1'h1, cyc - t0 >= RESET_DELAY_CYC - 2 &&
         cyc - t0 <= RESET_DELAY_CYC + 6)
      `CHK("cpu_rel", 1'h0, link.cpu_reset)
      sw_read(8'h14, s);
      `CHK("unmapped", 32'h0, s)
      isa_measure(hi, per);
      `CHK("isa_reset", 4, per)
      $display("test_reset done");
   endtask : test_reset

   // Code zero comes last and must keep the divide-by-eight before it.
   task automatic test_isa();
      int hi;
      int per;
      int dv;
      for (int c = 1; c <= 8; c++) begin
         dv = (c == 8) ? 8 : c + 1;
         sw_write(HOST_ISA_ADDR, {24'h0, 5'h0F, c[2:0]});
         wait_idle();
         isa_measure(hi, per);
         isa_measure(hi, per);
         `CHK("isa_per", dv, per)
         `CHK("isa_high", dv / 2, hi)
      end
      $display("test_isa done");
   endtask : test_isa

   task automatic test_dot(input logic [31:0] w, input logic [4:0] ps,
         input logic [3:0] is, input logic [11:0] fs, input logic [10:0] n,
         input logic en, input logic [1:0] sel);
      logic [31:0] s;
      sw_write(HOST_DOT_ADDR, w);
      sw_write(HOST_CMD_ADDR, 32'h1);
      for (int k = 0; k < 100 && {fb_rst, byp} !== 2'h3; k++) tick();
      `CHK("byp_fb", 2'h3, {fb_rst, byp})
      src_check(2'h0);
      wait_idle();
      repeat (4) tick();
      `CHK("post", ps, post_sc)
      `CHK("input", is, in_sc)
      `CHK("feedback", fs, fb_sc)
      `CHK("enable", en, pll_en)
      `CHK("half", w[HALF_OFF_BIT], half_off)
      `CHK("byp_off", 2'h0, {fb_rst, byp})
      sw_read(HOST_MIRROR_ADDR, s);
      `CHK("n_value", {1'h1, 5'h0, n}, s[16:0])
      src_check(sel);
      $display("test_dot done");
   endtask : test_dot

   // Reset, then the scenarios in order; the verdict closes the run.
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_reset <= 1'h0;
      @(posedge i_sys_clk);
      #1;
      test_reset();
      test_isa();
      test_dot(32'h0707_3805, 5'h02, 4'h7, 12'h084, 11'h042, 1'h1, 2'h2);
      test_dot(32'h4FBF_F407, 5'h01, 4'h9, 12'h003, 11'h001, 1'h1, 2'h1);
      test_dot(32'h1F2A_B000, 5'h00, 4'h2, 12'h012, 11'h009, 1'h0, 2'h3);
      print_verdict();
   end
endmodule : reset_and_clock_generation_bench
